// ==== logic/ebpdc_top.sv ====
// external bus pin drive control: output enables and pin sampling
`timescale 1ns/1ns
`default_nettype none
// Operation
// - without a grant bus pins float, except bus request, chip-selects during the reset hold, and pins set as output ports.
// - as master, data lines driven on writes only, floating on reads.
// - as master, acknowledge, transfer-ack and error lines are sampled as inputs.
// - not master, transfer-ack and error lines only listened, driven only as ports.
// - retry line sampled regardless of grant unless configured as output port, and driven only then.
// - bus request driven regardless of grant unless configured as input port.
// - bus grant pin is an input; driven only as an output port.
// - in reset the handshake pins are inputs with drivers floating.
// - burst/last pin input in reset, core controls its output afterwards.
// - bus_busy driven high for half a cycle after data phase, then floats; the code drives it high for one full clock.
// - bus acquired only with grant asserted and bus_busy negated by others.
module ebpdc_top
  import ebpdc_pkg::*;
#(
  parameter int RST_HOLD = EBPDC_RST_HOLD_CYCLES
) (
  input wire logic CORE_CLK, // system clock, 10 MHz
  input wire logic SYS_RST, // synchronous reset, active high
  input wire logic BUS_GRANT_N_IN, // bus_grant pin level
  input wire logic BUS_BUSY_N_IN, // bus_busy pin level
  input wire logic [EBPDC_HS_WIDTH-1:0] HS_IN, // handshake pin levels, active low
  input wire logic CORE_WANT_BUS, // core has a transfer pending
  input wire logic CORE_WRITE, // pending transfer is a write
  input wire logic CORE_DATA_DONE, // data phase terminated this cycle
  input wire logic [EBPDC_CS_WIDTH-1:0] CORE_CS, // chip-select values from core
  input wire logic CORE_BURST_LAST, // burst/last value from core
  input wire logic PORT_CS_OUT, // chip-select group assigned as output port
  input wire logic PORT_ADDR_OUT, // address group as output port
  input wire logic PORT_ADDR_IN, // address group as input port
  input wire logic PORT_DATA_OUT, // data group as output port
  input wire logic PORT_ATTR_OUT, // attribute group as output port
  input wire logic PORT_ATTR_IN, // attribute group as input port
  input wire logic [EBPDC_HS_WIDTH-1:0] PORT_HS_OUT, // handshake pins as output ports
  input wire logic [EBPDC_HS_WIDTH-1:0] PORT_HS_IN, // handshake pins as input ports
  input wire logic PORT_REQ_IN, // bus_request pin as input port
  input wire logic PORT_GRANT_OUT, // bus_grant pin as output port
  input wire logic PORT_BUSY_OUT, // bus_busy pin as output port
  input wire logic PORT_BUSY_IN, // bus_busy pin as input port
  output logic [EBPDC_CS_WIDTH-1:0] CS_O, // chip-select output level
  output logic CS_OE, // chip-select drive enable
  output logic ADDR_OE, // upper address drive enable
  output logic DATA_OE, // data drive enable
  output logic ATTR_OE, // attribute drive enable
  output logic [EBPDC_HS_WIDTH-1:0] HS_OE, // handshake drive enables
  output logic [EBPDC_HS_WIDTH-1:0] HS_SAMPLED, // sampled handshakes, active high
  output logic BURST_LAST_O, // burst/last output level
  output logic BUS_REQUEST_N_O, // bus_request output level
  output logic BUS_REQUEST_OE, // bus_request drive enable
  output logic BUS_GRANT_OE, // bus_grant drive enable
  output logic BUS_BUSY_N_O, // bus_busy output level
  output logic BUS_BUSY_OE, // bus_busy drive enable
  output logic MASTER // device holds the bus
);
  initial begin
    if (RST_HOLD < 1 || RST_HOLD > 255) $error("RST_HOLD out of range");
  end

  logic [EBPDC_HS_WIDTH+1:0] sync_out;
  logic grant_s, busy_s;
  logic [EBPDC_HS_WIDTH-1:0] hs_s;
  logic [7:0] hold_reg;
  logic cs_held_reg;
  logic master_reg;
  logic neg_phase_reg;
  ebpdc_bb_t bb_reg, bb_next;

  // pins come from outside the clock domain
  ebpdc_sync #(.WIDTH(EBPDC_HS_WIDTH + 2)) u_sync (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .d_in({~BUS_GRANT_N_IN, ~BUS_BUSY_N_IN, ~HS_IN}),
    .q_out(sync_out)
  );
  assign grant_s = sync_out[EBPDC_HS_WIDTH+1];
  assign busy_s = sync_out[EBPDC_HS_WIDTH];
  assign hs_s = sync_out[EBPDC_HS_WIDTH-1:0];

  // chip-select hold counter after reset release
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      hold_reg <= 8'h00;
      cs_held_reg <= 1'b1;
    end else if (cs_held_reg) begin
      hold_reg <= hold_reg + 8'h01;
      if (hold_reg == 8'(RST_HOLD - 1)) cs_held_reg <= 1'b0;
    end
  end

  // mastership: qualified grant needs bus_busy negated by others
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      master_reg <= 1'b0;
    end else if (!master_reg) begin
      master_reg <= CORE_WANT_BUS && grant_s && !busy_s;
    end else if (CORE_DATA_DONE && !CORE_WANT_BUS) begin
      master_reg <= 1'b0;
    end
  end

  // bus_busy release: drive high one step then float
  always_comb begin
    bb_next = bb_reg;
    unique case (bb_reg)
      EBPDC_BB_IDLE: if (master_reg) bb_next = EBPDC_BB_DRIVE;
      EBPDC_BB_DRIVE: if (CORE_DATA_DONE) bb_next = EBPDC_BB_NEGATE;
      EBPDC_BB_NEGATE: bb_next = master_reg ? EBPDC_BB_DRIVE : EBPDC_BB_IDLE;
      default: bb_next = EBPDC_BB_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) bb_reg <= EBPDC_BB_IDLE;
    else bb_reg <= bb_next;
  end

  // half-cycle negation: one-clock high stands for the half-cycle at this rate
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) neg_phase_reg <= 1'b0;
    else neg_phase_reg <= (bb_next == EBPDC_BB_NEGATE);
  end

  // chip-selects: reset level until the hold count runs out
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      CS_O <= EBPDC_CS_RESET;
      CS_OE <= 1'b1;
    end else begin
      CS_O <= cs_held_reg ? EBPDC_CS_RESET : CORE_CS;
      CS_OE <= cs_held_reg || master_reg || PORT_CS_OUT;
    end
  end

  // address and attributes; an input-port setting floats them even as master
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ADDR_OE <= 1'b0;
      ATTR_OE <= 1'b0;
    end else begin
      ADDR_OE <= (master_reg && !PORT_ADDR_IN) || PORT_ADDR_OUT;
      ATTR_OE <= (master_reg && !PORT_ATTR_IN) || PORT_ATTR_OUT;
    end
  end

  // data lines: reads leave them to the slave, avoiding contention
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) DATA_OE <= 1'b0;
    else DATA_OE <= (master_reg && CORE_WRITE) || PORT_DATA_OUT;
  end

  // handshake pins, one slice per pin
  for (genvar gi = 0; gi < EBPDC_HS_WIDTH; gi++) begin : g_hs
    // transfer start and burst/last drive as master, the rest only listen
    if (gi == EBPDC_HS_TSTART || gi == EBPDC_HS_BURST) begin : g_out
      always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) HS_OE[gi] <= 1'b0;
        else HS_OE[gi] <= (master_reg && !PORT_HS_IN[gi]) || PORT_HS_OUT[gi];
      end
    end else begin : g_in
      always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) HS_OE[gi] <= 1'b0;
        else HS_OE[gi] <= PORT_HS_OUT[gi];
      end
    end
    // sampling ignores the grant, so a late retry is still seen
    always_ff @(posedge CORE_CLK) begin
      if (SYS_RST) HS_SAMPLED[gi] <= 1'b0;
      else HS_SAMPLED[gi] <= hs_s[gi] && !PORT_HS_OUT[gi];
    end
  end

  // burst/last level taken from the core, inverted, once reset is over
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) BURST_LAST_O <= 1'b1;
    else BURST_LAST_O <= ~CORE_BURST_LAST;
  end

  // bus request: independent of the grant, floats only as an input port
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      BUS_REQUEST_N_O <= 1'b1;
      BUS_REQUEST_OE <= 1'b0;
    end else begin
      BUS_REQUEST_N_O <= ~(CORE_WANT_BUS && !master_reg);
      BUS_REQUEST_OE <= !PORT_REQ_IN;
    end
  end

  // bus grant pin is ours to drive only as an output port
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) BUS_GRANT_OE <= 1'b0;
    else BUS_GRANT_OE <= PORT_GRANT_OUT;
  end

  // bus_busy: driven high for one clock before floating, so the pull-up
  // does not have to lift the line on its own
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      BUS_BUSY_N_O <= 1'b1;
      BUS_BUSY_OE <= 1'b0;
    end else begin
      BUS_BUSY_N_O <= ~(bb_next == EBPDC_BB_DRIVE);
      BUS_BUSY_OE <= ((bb_next != EBPDC_BB_IDLE) && !PORT_BUSY_IN)
        || PORT_BUSY_OUT;
    end
  end

  // mastership seen outside one clock after the internal flag
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) MASTER <= 1'b0;
    else MASTER <= master_reg;
  end

  logic unused_ok;
  assign unused_ok = neg_phase_reg;
endmodule : ebpdc_top
`default_nettype wire

// ==== logic/ebpdc_pkg.sv ====
// constants shared by the external bus pin drive control block
package ebpdc_pkg;
  localparam int EBPDC_RST_HOLD_CYCLES = 5;   // chip-select release delay after reset
  localparam int EBPDC_CS_WIDTH = 12;         // combined chip-select / low address lines
  localparam int EBPDC_ADDR_WIDTH = 18;       // upper address lines
  localparam int EBPDC_DATA_WIDTH = 32;       // data lines
  localparam int EBPDC_ATTR_WIDTH = 11;       // write, burst, byte enables, attributes, types
  localparam logic [11:0] EBPDC_CS_RESET = 12'hfff; // chip-selects held high in reset
  // handshake pin indices within the handshake group
  localparam int EBPDC_HS_TSTART = 0;
  localparam int EBPDC_HS_ADDRESS_ACKNOWLEDGE = 1;
  localparam int EBPDC_HS_TACK = 2;
  localparam int EBPDC_HS_TERR = 3;
  localparam int EBPDC_HS_RETRY = 4;
  localparam int EBPDC_HS_BURST = 5;
  localparam int EBPDC_HS_INHIBIT = 6;
  localparam int EBPDC_HS_WIDTH = 7;
  // bus_busy release sequence
  typedef enum logic [1:0] {
    EBPDC_BB_IDLE = 2'b00,
    EBPDC_BB_DRIVE = 2'b01,
    EBPDC_BB_NEGATE = 2'b11
  } ebpdc_bb_t;
endpackage : ebpdc_pkg

// ==== logic/ebpdc_sync.sv ====
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ns
`default_nettype none
module ebpdc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // sampling clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [WIDTH-1:0] d_in, // asynchronous pin levels
  output logic [WIDTH-1:0] q_out // synchronised levels
);
  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      q_out <= '0;
    end else begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule : ebpdc_sync
`default_nettype wire

// ==== verification/ebpdc_far_model.sv ====
// far side: arbiter grant, another master on bus_busy, slaves pulling handshakes low
`timescale 1ns/1ns
`default_nettype none
module ebpdc_far_model (
  input wire logic clk, // clock
  input wire logic give, // grant us
  input wire logic other_busy, // other master busy
  input wire logic busy_oe, // our busy enable
  input wire logic busy_n_o, // our busy level
  input wire logic [6:0] hs_pull, // slaves pulling handshakes low
  output logic grant_n, // grant pin
  output logic busy_n, // busy wire
  output logic [6:0] hs_n // handshakes
);
  // arbiter moves grant just after the edge
  always_ff @(posedge clk) grant_n <= !give;
  // pulled-up wire, other master pulls low
  always_comb busy_n = other_busy ? 1'h0 : (busy_oe ? busy_n_o : 1'h1);
  assign hs_n = ~hs_pull; // released lines go high through pull-ups
endmodule // ebpdc_far_model
`default_nettype wire

// ==== verification/ebpdc_top_asserts.sv ====
// checker on the pin drive control ports
`timescale 1ns/1ns
`default_nettype none
module ebpdc_top_asserts
  import ebpdc_pkg::*;
(
  input wire logic CORE_CLK, // in
  input wire logic SYS_RST, // in
  input wire logic BUS_GRANT_N_IN, // in
  input wire logic BUS_BUSY_N_IN, // in
  input wire logic CORE_WANT_BUS, // in
  input wire logic CORE_WRITE, // in
  input wire logic CORE_DATA_DONE, // in
  input wire logic PORT_DATA_OUT, // in
  input wire logic [EBPDC_HS_WIDTH-1:0] PORT_HS_OUT, // in
  input wire logic PORT_REQ_IN, // in
  input wire logic PORT_BUSY_OUT, // in
  input wire logic [EBPDC_CS_WIDTH-1:0] CS_O, // out
  input wire logic CS_OE, // out
  input wire logic DATA_OE, // out
  input wire logic [EBPDC_HS_WIDTH-1:0] HS_OE, // out
  input wire logic BUS_REQUEST_OE, // out
  input wire logic BUS_BUSY_N_O, // out
  input wire logic BUS_BUSY_OE, // out
  input wire logic MASTER // out
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  a_reset_pins: assert property (disable iff (1'h0)
    $fell(SYS_RST) |-> CS_O == EBPDC_CS_RESET && CS_OE && HS_OE == 7'h0) else $error("reset");
  a_cs_hold: assert property ($fell(SYS_RST) |->
    (CS_O == EBPDC_CS_RESET) [*5]) else $error("cs early");
  a_master_qual: assert property ($rose(MASTER) |->
    !$past(BUS_GRANT_N_IN, 4) && $past(BUS_BUSY_N_IN, 4)) else $error("grant");
  a_data_dir: assert property (MASTER && $past(MASTER) && !$past(PORT_DATA_OUT) |->
    DATA_OE == $past(CORE_WRITE)) else $error("data dir");
  a_hs_listen: assert property (!$past(SYS_RST) |->
    (HS_OE & 7'h5e & ~$past(PORT_HS_OUT)) == 7'h0) else $error("hs driven");
  a_req_drive: assert property (!$past(SYS_RST) && !$past(PORT_REQ_IN) |->
    BUS_REQUEST_OE) else $error("request");
  a_port_wins: assert property (!$past(SYS_RST) && $past(PORT_DATA_OUT) |->
    DATA_OE) else $error("port");
  a_busy_release: assert property (MASTER && CORE_DATA_DONE && !CORE_WANT_BUS &&
    !PORT_BUSY_OUT |=> BUS_BUSY_OE && BUS_BUSY_N_O ##1 !BUS_BUSY_OE) else $error("busy");
endmodule // ebpdc_top_asserts
bind ebpdc_top ebpdc_top_asserts u_ebpdc_top_asserts (.*);
`default_nettype wire

// ==== verification/test_ebpdc_top.sv ====
// bench for the pin drive control block
`timescale 1ns/1ns
`default_nettype none
module test_ebpdc_top;
  logic clk = 1'h0, rst = 1'h1, want = 1'h0, wr = 1'h0, done = 1'h0, give = 1'h0, ob = 1'h0;
  logic [9:0] pc = 10'h0; // port assignment bits, bit 9 the core burst/last value
  logic [6:0] hso = 7'h0, hs_n, hs_oe;
  logic [11:0] cs_o;
  logic gn, bn, bno, boe, m, doe, roe, goe, cso, aoe, toe, blo, rqn;
  logic [6:0] smp, hsp = 7'h0;
  int failures = 0, check_count = 0, cyc = 0, k;
  ebpdc_top u_ebpdc_top (.CORE_CLK(clk), .SYS_RST(rst), .BUS_GRANT_N_IN(gn), .BUS_BUSY_N_IN(bn),
    .HS_IN(hs_n), .CORE_WANT_BUS(want), .CORE_WRITE(wr), .CORE_DATA_DONE(done),
    .CORE_CS(12'h5a3), .CORE_BURST_LAST(pc[9]), .PORT_CS_OUT(pc[0]), .PORT_ADDR_OUT(pc[1]),
    .PORT_ADDR_IN(pc[2]), .PORT_DATA_OUT(pc[3]), .PORT_ATTR_OUT(pc[4]), .PORT_ATTR_IN(pc[5]),
    .PORT_HS_OUT(hso), .PORT_HS_IN(7'h0), .PORT_REQ_IN(pc[6]), .PORT_GRANT_OUT(pc[7]),
    .PORT_BUSY_OUT(1'h0), .PORT_BUSY_IN(pc[8]), .CS_O(cs_o), .CS_OE(cso), .ADDR_OE(aoe),
    .DATA_OE(doe), .ATTR_OE(toe), .HS_OE(hs_oe), .HS_SAMPLED(smp), .BURST_LAST_O(blo),
    .BUS_REQUEST_N_O(rqn), .BUS_REQUEST_OE(roe), .BUS_GRANT_OE(goe), .BUS_BUSY_N_O(bno),
    .BUS_BUSY_OE(boe), .MASTER(m));
  ebpdc_far_model u_ebpdc_far_model (.clk(clk), .give(give), .other_busy(ob), .busy_oe(boe),
    .busy_n_o(bno), .hs_pull(hsp), .grant_n(gn), .busy_n(bn), .hs_n(hs_n));
  initial forever #50 clk = !clk;
  // hang guard, well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      failures++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // chip-selects follow the core only after the hold time
  task automatic t_reset();
    tick(5);
    @(posedge clk) rst <= 1'h0;
    tick(10);
    chk(cs_o, 12'h5a3);
  endtask
  // no grant: only the request line drives
  task automatic t_idle();
    @(posedge clk) begin
      want <= 1'h1;
      hsp <= 7'h7f;
    end
    tick(6);
    chk({m, doe, hs_oe, roe, goe}, 11'h2);
    chk({cso, aoe, toe, rqn, blo, smp}, 12'h0ff);
  endtask
  // grant refused while busy, then write, read and release
  task automatic t_master();
    @(posedge clk) begin
      give <= 1'h1;
      wr <= 1'h1;
      ob <= 1'h1;
    end
    tick(8);
    chk(m, 1'h0);
    @(posedge clk) ob <= 1'h0;
    for (k = 0; k < 9 && m !== 1'h1; k++) tick(1);
    tick(1);
    chk({m, doe, hs_oe & 7'h5e}, 9'h180);
    chk({cso, aoe, toe, rqn}, 4'hf);
    @(posedge clk) wr <= 1'h0;
    tick(2);
    chk({m, doe}, 2'h2);
    @(posedge clk) begin
      done <= 1'h1;
      want <= 1'h0;
    end
    @(posedge clk) done <= 1'h0;
    #1;
    chk({boe, bno}, 2'h3);
    tick(1);
    chk(boe, 1'h0);
  endtask
  // port assignment overrides bus direction
  task automatic t_ports();
    @(posedge clk) begin
      give <= 1'h0;
      pc <= 10'h3ff;
      hso <= 7'h1c;
    end
    tick(6);
    chk({doe, hs_oe, roe, goe}, 10'h271);
    chk({cso, aoe, toe, rqn, blo, smp}, 12'hf63);
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_idle();
    t_master();
    t_ports();
    final_report();
  end
endmodule // test_ebpdc_top
`default_nettype wire
